// ==== hw/mdio_pkg.sv ====
// Purpose: Shared constants and carriers for the motor I/O status block
// Assumes: 250 MHz hclk, AHB-Lite register access, 32-bit words
// Notes:   Offsets are byte addresses of aligned words
package mdio_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CONFIG   = 8'h00;
   localparam logic [7:0] OFS_BAND     = 8'h04;
   localparam logic [7:0] OFS_NETIN    = 8'h08;
   localparam logic [7:0] OFS_NETOUT   = 8'h0c;
   localparam logic [7:0] OFS_ROUTE    = 8'h10;
   localparam logic [7:0] OFS_STATUS   = 8'h14;
   localparam logic [7:0] OFS_ECHO     = 8'h18;
   localparam logic [7:0] OFS_DEVIATE  = 8'h1c;
   localparam logic [7:0] OFS_GPOL     = 8'h20;
   // Config field positions
   localparam int CFG_STEP_EN  = 0;
   localparam int CFG_ACT_LO   = 1;
   localparam int CFG_OT_EN    = 3;
   localparam int CFG_OT_DECEL = 4;
   localparam int CFG_LS_NC    = 5;
   localparam int CFG_HS_NC    = 6;
   localparam int CFG_SLIT_NC  = 7;
   localparam int CFG_SLIT_USE = 8;
   // Reset values and band limits
   localparam logic [8:0]  CFG_RESET  = 9'h008;
   localparam logic [11:0] BAND_RESET = 12'h048;
   localparam logic [11:0] BAND_MIN   = 12'h001;
   localparam logic [11:0] BAND_MAX   = 12'he10;
   // Action encodings
   localparam logic [1:0] ACT_NONE  = 2'h0;
   localparam logic [1:0] ACT_WARN  = 2'h1;
   localparam logic [1:0] ACT_ALARM = 2'h2;
   // Index pulse timing
   localparam int CLK_MHZ      = 250;
   localparam int IDX_MIN_US   = 1000;
   localparam int IDX_MAX_US   = 3000;
   localparam int IDX_HOLD_CYC = IDX_MIN_US * CLK_MHZ;
   localparam int IDX_LAT_CYC  = IDX_MAX_US * CLK_MHZ;
   // Sensor inputs as one carrier
   typedef struct packed {
      logic pos_limit;
      logic neg_limit;
      logic home_sensor;
      logic slit;
      logic encoder_index;
   } mdio_sensor_type;
   // Operation inputs that get echoed
   typedef struct packed {
      logic dir_fwd;
      logic dir_rvs;
      logic home_cmd;
      logic start;
      logic jog_pos;
      logic jog_neg;
      logic data_sel;
      logic free;
      logic stop;
   } mdio_op_type;
endpackage

// ==== hw/mdio_status.sv ====
// Purpose: Status outputs, sensor handling and general signals of a driver
// Assumes: Single 250 MHz clock; sensors and direct inputs are asynchronous
// Notes:   Registers reached over AHB-Lite, zero wait states, OKAY always
// Functional notes
// - Main-power output follows the main supply being on.
// - Loss-of-sync output set when enabled deviation reaches the band.
// - Loss-of-sync detection enable bit, reset to disabled.
// - Band in 0.1 degree units, 1 to 3600, default 72.
// - Two-bit action: none, warning or alarm; default none.
// - Overheat output follows the overheat warning, clears itself.
// - Encoder index output answers the encoder index input.
// - Index output follows movement within 3 ms.
// - Brake-released output follows the brake state.
// - Response outputs mirror input levels, not motor motion.
// - Limits feed home-seeking in homing, else overtravel stop.
// - Hardware overtravel enable bit, reset to enabled.
// - Overtravel stop kind: immediate or deceleration, default immediate.
// - Limit polarity: normally open or closed, default open.
// - Home sensor used as mechanical home in 3-sensor mode.
// - Home sensor polarity setting, default normally open.
// - Slit optionally combined with home sensor; own polarity.
// - Sixteen general signals between direct I/O and network bits.
// - Network input bit drives its direct output.
// - Direct input, after polarity, reports on network output bit.
`timescale 1ns/10ps
`default_nettype none
module mdio_status
(
   // Clock and reset
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   // Driver state from the core
   input  wire logic                      main_power_on,
   input  wire logic                      overheat_warn,
   input  wire logic                      brake_released,
   input  wire logic                      homing_active,
   input  wire logic                      three_sensor_mode,
   input  wire logic [15:0]               deviation,
   input  wire mdio_pkg::mdio_op_type     op_in,
   // Sensor pins
   input  wire mdio_pkg::mdio_sensor_type sensor_in,
   input  wire logic [15:0]               direct_in,
   // Status outputs
   output logic                           main_power_status,
   output logic                           stepout_out,
   output logic                           stepout_warn,
   output logic                           stepout_alarm,
   output logic                           overheat_out,
   output logic                           encoder_index_out,
   output logic                           brake_released_out,
   output mdio_pkg::mdio_op_type          op_echo,
   output mdio_pkg::mdio_sensor_type      sensor_echo,
   // Homing and overtravel
   output logic                           home_pos_limit,
   output logic                           home_neg_limit,
   output logic                           home_mark,
   output logic                           overtravel_stop,
   output logic                           overtravel_decel,
   // General signals
   output logic      [15:0]               direct_out
);
   // Register state
   logic [8:0]  cfg_q;
   logic [1:0]  act_q;
   logic [11:0] band_q;
   logic [15:0] netin_q;
   logic [15:0] route_q;
   logic [15:0] gpol_q;
   logic [15:0] netout_q;
   // Bus data phase
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   // Synchronisers
   logic [4:0]  sens_s1_q;
   logic [4:0]  sens_s2_q;
   logic [15:0] din_s1_q;
   logic [15:0] din_s2_q;
   // Index pulse stretch
   logic        idx_prev_q;
   logic [19:0] idx_cnt_q;
   logic [31:0] rd_d;
   logic        pos_act;
   logic        neg_act;
   logic        home_act;
   logic        slit_act;
   // One clock domain, so all assertions share these defaults
   default clocking dflt_cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // Clamp a band write into the legal range
   function automatic logic [11:0] clamp_band(input logic [31:0] v);
      if (v[31:0] < {20'h0, mdio_pkg::BAND_MIN})
         clamp_band = mdio_pkg::BAND_MIN;
      else if (v[31:0] > {20'h0, mdio_pkg::BAND_MAX})
         clamp_band = mdio_pkg::BAND_MAX;
      else
         clamp_band = v[11:0];
   endfunction

   // Apply normally-closed polarity
   function automatic logic apply_pol(input logic lvl, input logic nc);
      apply_pol = lvl ^ nc;
   endfunction

   // Two-stage sync; first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sens_s1_q <= 5'h00;
         sens_s2_q <= 5'h00;
         din_s1_q  <= 16'h0000;
         din_s2_q  <= 16'h0000;
      end
      else
      begin
         sens_s1_q <= sensor_in;
         sens_s2_q <= sens_s1_q;
         din_s1_q  <= direct_in;
         din_s2_q  <= din_s1_q;
      end
   end

   // Polarity applied to synchronised sensors
   assign pos_act  = apply_pol(sens_s2_q[4],
                               cfg_q[mdio_pkg::CFG_LS_NC]);
   assign neg_act  = apply_pol(sens_s2_q[3],
                               cfg_q[mdio_pkg::CFG_LS_NC]);
   assign home_act = apply_pol(sens_s2_q[2],
                               cfg_q[mdio_pkg::CFG_HS_NC]);
   assign slit_act = apply_pol(sens_s2_q[1],
                               cfg_q[mdio_pkg::CFG_SLIT_NC]);

   // Write capture: address phase then data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end
      else if (hready)
      begin
         wr_pend_q <= hsel & htrans[1] & hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   // Software settings; aligned offsets only, hsize ignored so any write sets the whole word
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_q   <= mdio_pkg::CFG_RESET;
         act_q   <= mdio_pkg::ACT_NONE;
         band_q  <= mdio_pkg::BAND_RESET;
         netin_q <= 16'h0000;
         route_q <= 16'h0000;
         gpol_q  <= 16'h0000;
      end
      else if (wr_pend_q)
      begin
         case (wr_addr_q)
            mdio_pkg::OFS_CONFIG:
            begin
               cfg_q <= {hwdata[8:3], 2'h0, hwdata[0]};
               act_q <= (hwdata[2:1] == 2'h3) ? mdio_pkg::ACT_NONE
                                              : hwdata[2:1];
            end
            mdio_pkg::OFS_BAND:  band_q  <= clamp_band(hwdata);
            mdio_pkg::OFS_NETIN: netin_q <= hwdata[15:0];
            mdio_pkg::OFS_ROUTE: route_q <= hwdata[15:0];
            mdio_pkg::OFS_GPOL:  gpol_q  <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped reads return zero
   always_comb
   begin
      rd_d = 32'h0000_0000;
      case (haddr[7:0])
         mdio_pkg::OFS_CONFIG:
            rd_d = {23'h0, cfg_q[8:3], act_q, cfg_q[0]};
         mdio_pkg::OFS_BAND:    rd_d = {20'h0, band_q};
         mdio_pkg::OFS_NETIN:   rd_d = {16'h0, netin_q};
         mdio_pkg::OFS_NETOUT:  rd_d = {16'h0, netout_q};
         mdio_pkg::OFS_ROUTE:   rd_d = {16'h0, route_q};
         mdio_pkg::OFS_STATUS:
            rd_d = {20'h0, overtravel_stop, stepout_alarm, stepout_warn,
                    stepout_out, brake_released_out, encoder_index_out,
                    overheat_out, main_power_status, sensor_echo[4:1]};
         mdio_pkg::OFS_ECHO:    rd_d = {23'h0, op_echo};
         mdio_pkg::OFS_DEVIATE: rd_d = {16'h0, deviation};
         mdio_pkg::OFS_GPOL:    rd_d = {16'h0, gpol_q};
         default:               rd_d = 32'h0000_0000;
      endcase
   end

   // Read data registered; answer in the data phase with no wait
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         if (hready & hsel & htrans[1] & ~hwrite)
            hrdata <= rd_d;
         hreadyout <= 1'b1;                   // Never stalls
         hresp     <= 1'b0;                   // OKAY only
      end
   end

   // Plain status followers, one cycle of latency
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         main_power_status  <= 1'b0;
         overheat_out       <= 1'b0;
         brake_released_out <= 1'b0;
      end
      else
      begin
         main_power_status  <= main_power_on;
         overheat_out       <= overheat_warn;
         brake_released_out <= brake_released;
      end
   end

   // Loss of synchronism; deviation in 0.1 degree units
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         stepout_out   <= 1'b0;
         stepout_warn  <= 1'b0;
         stepout_alarm <= 1'b0;
      end
      else
      begin
         stepout_out   <= cfg_q[mdio_pkg::CFG_STEP_EN]
                          & (deviation >= {4'h0, band_q});
         stepout_warn  <= cfg_q[mdio_pkg::CFG_STEP_EN]
                          & (deviation >= {4'h0, band_q})
                          & (act_q == mdio_pkg::ACT_WARN);
         stepout_alarm <= cfg_q[mdio_pkg::CFG_STEP_EN]
                          & (deviation >= {4'h0, band_q})
                          & (act_q == mdio_pkg::ACT_ALARM);
      end
   end

   // Index output: rising edge starts a 1 ms pulse.
   // Stretching keeps short glitches visible; latency is 3 cycles.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         idx_prev_q        <= 1'b0;
         idx_cnt_q         <= 20'h00000;
         encoder_index_out <= 1'b0;
      end
      else
      begin
         idx_prev_q <= sens_s2_q[0];
         if (sens_s2_q[0] & ~idx_prev_q)
         begin
            idx_cnt_q         <= 20'(mdio_pkg::IDX_HOLD_CYC - 1);
            encoder_index_out <= 1'b1;
         end
         else if (idx_cnt_q != 20'h00000)
            idx_cnt_q <= idx_cnt_q - 20'h00001;
         else
            encoder_index_out <= sens_s2_q[0];  // Long pulses held
      end
   end

   // Echoes of input levels, never of motor motion
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         op_echo     <= '0;
         sensor_echo <= '0;
      end
      else
      begin
         op_echo     <= op_in;
         sensor_echo <= {pos_act, neg_act, home_act, slit_act,
                         sens_s2_q[0]};
      end
   end

   // Limits: homing gets them, otherwise overtravel stop
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         home_pos_limit   <= 1'b0;
         home_neg_limit   <= 1'b0;
         home_mark        <= 1'b0;
         overtravel_stop  <= 1'b0;
         overtravel_decel <= 1'b0;
      end
      else
      begin
         home_pos_limit  <= homing_active & pos_act;
         home_neg_limit  <= homing_active & neg_act;
         // Slit narrows the home window when enabled
         home_mark <= homing_active & three_sensor_mode & home_act
                  & (slit_act | ~cfg_q[mdio_pkg::CFG_SLIT_USE]);
         overtravel_stop <= ~homing_active & cfg_q[mdio_pkg::CFG_OT_EN]
                            & (pos_act | neg_act);
         overtravel_decel <= cfg_q[mdio_pkg::CFG_OT_DECEL];
      end
   end

   // General signals: network to outputs, inputs to network
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         direct_out <= 16'h0000;
         netout_q   <= 16'h0000;
      end
      else
      begin
         direct_out <= netin_q & route_q;
         netout_q   <= (din_s2_q ^ gpol_q) & ~route_q;
      end
   end

   // Assertions; followers skip the first edge after a reset release
   a_power_follow: assert property (
      $past(hresetn) |-> main_power_status == $past(main_power_on))
      else $error("main power status lags");
   a_stepout_gate: assert property (
      !$past(cfg_q[mdio_pkg::CFG_STEP_EN]) |-> !stepout_out)
      else $error("stepout while disabled");
   a_stepout_band: assert property (
      $past(cfg_q[0]) && $past(deviation) >= {4'h0, $past(band_q)}
      |-> stepout_out)
      else $error("stepout missed");
   a_band_range: assert property (
      band_q >= mdio_pkg::BAND_MIN && band_q <= mdio_pkg::BAND_MAX)
      else $error("band out of range");
   a_action_excl: assert property (
      !(stepout_warn && stepout_alarm) && (!stepout_warn || stepout_out))
      else $error("action outputs clash");
   a_heat_follow: assert property (
      $fell(overheat_warn) |=> !overheat_out)
      else $error("overheat not cleared");
   a_index_rise: assert property (
      $rose(sensor_in.encoder_index) ##1 sensor_in.encoder_index[*2]
      |-> ##[1:3] encoder_index_out)
      else $error("index output late");
   a_brake_follow: assert property (
      $past(hresetn) |-> brake_released_out == $past(brake_released))
      else $error("brake output wrong");
   a_echo_level: assert property (
      $past(hresetn) |-> op_echo == $past(op_in))
      else $error("echo mismatch");
   a_ot_homing: assert property (
      $past(homing_active) |-> !overtravel_stop)
      else $error("overtravel during homing");
   a_ot_limit: assert property (
      !$past(homing_active) && $past(cfg_q[3]) && $past(pos_act)
      |-> overtravel_stop)
      else $error("overtravel missed");
   a_gen_out: assert property (
      $past(hresetn) |-> direct_out == $past(netin_q & route_q))
      else $error("general output wrong");
   c_stepout: cover property (@(posedge hclk) $rose(stepout_alarm));
   c_overtravel: cover property (@(posedge hclk) $rose(overtravel_stop));
   c_index: cover property (@(posedge hclk) $rose(encoder_index_out));
   c_home: cover property (@(posedge hclk) $rose(home_mark));
endmodule
`default_nettype wire

// ==== tb/mdio_sensor_model.sv ====
// Purpose: Far-side model: limit, home, slit sensors, encoder, direct pins
// Assumes: Raw pin sense; lag of 0 answers at once, up to 7 cycles late
// Notes:   Index hold is a parameter so the bench can send short pulses
`timescale 1ns/10ps
`default_nettype none
module mdio_sensor_model
#(
   parameter int IDX_HOLD = 250000
)
(
   // Clock
   input  wire logic                      hclk,
   // Levels the bench asks for
   input  wire logic [3:0]                want_pins,
   input  wire logic [15:0]               want_direct,
   input  wire logic [2:0]                lag,
   input  wire logic                      index_go,
   // Pins seen by the block
   output mdio_pkg::mdio_sensor_type      sensor_in,
   output logic      [15:0]               direct_in
);
   logic [19:0] stage_q [0:7] = '{default: 20'h0};
   logic [19:0] sel;
   logic [31:0] idx_cnt_q = 32'h0;

   // Delay line so a slow sensor or cable can be modelled
   always_ff @(posedge hclk)
   begin
      stage_q[0] <= {want_pins, want_direct};
      for (int i = 1; i < 8; i++)
         stage_q[i] <= stage_q[i-1];
   end

   // Encoder holds index for the set span
   always_ff @(posedge hclk)
   begin
      if (index_go)
         idx_cnt_q <= IDX_HOLD;
      else if (idx_cnt_q != 32'h0)
         idx_cnt_q <= idx_cnt_q - 32'h1;
   end

   // Pick prompt or lagged levels
   always_comb
   begin
      sel = (lag == 3'h0) ? {want_pins, want_direct} : stage_q[lag - 3'h1];
   end

   assign sensor_in = mdio_pkg::mdio_sensor_type'({sel[19:16],
                                                   idx_cnt_q != 32'h0});
   assign direct_in = sel[15:0];
endmodule
`default_nettype wire

// ==== tb/mdio_status_tb.sv ====
// Purpose: Self-checking bench for the motor I/O status block
// Assumes: Zero-wait AHB-Lite slave; sensors reach outputs in 3 cycles
// Notes:   Short index pulse only; the 1 ms stretch is too long to run
`timescale 1ns/10ps
`default_nettype none
module mdio_status_tb;
   typedef struct packed {
      logic [8:0]  cfg;
      logic [11:0] band;
      logic [15:0] dev;
      logic [3:0]  pins;
      logic        homing;
      logic        tsm;
      logic [7:0]  expect_bits;
   } mdio_row_type;

   logic hclk, hresetn, hsel, hwrite, hready, hresp, hreadyout;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, lag;
   logic main_power_on, overheat_warn, brake_released, homing_active;
   logic three_sensor_mode, index_go;
   logic main_power_status, stepout_out, stepout_warn, stepout_alarm;
   logic overheat_out, encoder_index_out, brake_released_out;
   logic home_pos_limit, home_neg_limit, home_mark;
   logic overtravel_stop, overtravel_decel;
   logic [15:0] deviation, direct_in, direct_out, want_direct;
   logic [3:0]  want_pins;
   logic [7:0]  outs;
   mdio_pkg::mdio_op_type     op_in, op_echo;
   mdio_pkg::mdio_sensor_type sensor_in, sensor_echo;
   int err_count = 0;
   int checks_done = 0;

   // Stepout, overtravel and homing rows: pins are pos, neg, home, slit
   mdio_row_type rows [0:17] = '{
      '{9'h001, 12'h048, 16'h0048, 4'h0, 1'h0, 1'h0, 8'h80},
      '{9'h003, 12'h048, 16'h0047, 4'h0, 1'h0, 1'h0, 8'h00},
      '{9'h003, 12'h048, 16'h0048, 4'h0, 1'h0, 1'h0, 8'hc0},
      '{9'h005, 12'h001, 16'h0001, 4'h0, 1'h0, 1'h0, 8'ha0},
      '{9'h004, 12'h001, 16'h0064, 4'h0, 1'h0, 1'h0, 8'h00},
      '{9'h007, 12'h00a, 16'h0014, 4'h0, 1'h0, 1'h0, 8'h80},
      '{9'h008, 12'he10, 16'h0000, 4'h8, 1'h0, 1'h0, 8'h10},
      '{9'h018, 12'he10, 16'h0000, 4'h4, 1'h0, 1'h0, 8'h18},
      '{9'h028, 12'he10, 16'h0000, 4'h4, 1'h0, 1'h0, 8'h10},
      '{9'h028, 12'he10, 16'h0000, 4'hc, 1'h0, 1'h0, 8'h00},
      '{9'h000, 12'he10, 16'h0000, 4'h8, 1'h0, 1'h0, 8'h00},
      '{9'h008, 12'he10, 16'h0000, 4'h8, 1'h1, 1'h0, 8'h04},
      '{9'h008, 12'he10, 16'h0000, 4'h4, 1'h1, 1'h0, 8'h02},
      '{9'h008, 12'he10, 16'h0000, 4'h2, 1'h1, 1'h1, 8'h01},
      '{9'h108, 12'he10, 16'h0000, 4'h2, 1'h1, 1'h1, 8'h00},
      '{9'h108, 12'he10, 16'h0000, 4'h3, 1'h1, 1'h1, 8'h01},
      '{9'h0c8, 12'he10, 16'h0000, 4'h0, 1'h1, 1'h1, 8'h01},
      '{9'h008, 12'he10, 16'h0000, 4'h2, 1'h1, 1'h0, 8'h00}};

   assign hready = hreadyout;
   assign outs = {stepout_out, stepout_warn, stepout_alarm, overtravel_stop,
                  overtravel_decel, home_pos_limit, home_neg_limit, home_mark};

   mdio_status mdio_status_inst
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .main_power_on(main_power_on), .overheat_warn(overheat_warn),
      .brake_released(brake_released), .homing_active(homing_active),
      .three_sensor_mode(three_sensor_mode), .deviation(deviation),
      .op_in(op_in), .sensor_in(sensor_in), .direct_in(direct_in),
      .main_power_status(main_power_status), .stepout_out(stepout_out),
      .stepout_warn(stepout_warn), .stepout_alarm(stepout_alarm),
      .overheat_out(overheat_out), .encoder_index_out(encoder_index_out),
      .brake_released_out(brake_released_out), .op_echo(op_echo),
      .sensor_echo(sensor_echo), .home_pos_limit(home_pos_limit),
      .home_neg_limit(home_neg_limit), .home_mark(home_mark),
      .overtravel_stop(overtravel_stop), .overtravel_decel(overtravel_decel),
      .direct_out(direct_out)
   );

   // Short hold on purpose: the block must stretch it
   mdio_sensor_model #(.IDX_HOLD(40)) mdio_sensor_model_inst
   (
      .hclk(hclk), .want_pins(want_pins), .want_direct(want_direct),
      .lag(lag), .index_go(index_go), .sensor_in(sensor_in),
      .direct_in(direct_in)
   );

   // Clock, 4 ns period
   initial
   begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // Verdict and end of run
   task automatic conclude();
      if (err_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Word results
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Pin level results
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      chk32({16'h0, got}, {16'h0, exp});
   endtask

   // One single AHB-Lite transfer; address held until hready seen high
   task automatic ahb(input logic wr, input logic [7:0] adr,
                      input logic [31:0] wdat, output logic [31:0] rdat);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h0, adr};
      hwrite <= wr;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdat;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask

   // Hang guard, well past the expected run length
   initial
   begin
      repeat (20000) @(posedge hclk);
      err_count++;
      conclude();
   end

   // Main sequence
   initial
   begin
      hresetn = 1'b0;  hsel = 1'b0;  haddr = 32'h0;  htrans = 2'h0;
      hwrite = 1'b0;  hsize = 3'h2;  hwdata = 32'h0;  lag = 3'h0;
      main_power_on = 1'b0;  overheat_warn = 1'b0;  brake_released = 1'b0;
      homing_active = 1'b0;  three_sensor_mode = 1'b0;  index_go = 1'b0;
      deviation = 16'h0;  op_in = 9'h0;  want_pins = 4'h0;
      want_direct = 16'h1234;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      for (int r = 0; r < 18; r++)
      begin
         @(posedge hclk);
         deviation         <= rows[r].dev;
         want_pins         <= rows[r].pins;
         homing_active     <= rows[r].homing;
         three_sensor_mode <= rows[r].tsm;
         ahb(1'b1, mdio_pkg::OFS_CONFIG, {23'h0, rows[r].cfg}, rd);
         ahb(1'b1, mdio_pkg::OFS_BAND, {20'h0, rows[r].band}, rd);
         repeat (6) @(posedge hclk);
         chk16({8'h0, outs}, {8'h0, rows[r].expect_bits}); // Flags
         chk16({11'h0, sensor_echo}, {11'h0, rows[r].pins ^ {rows[r].cfg[5],
               rows[r].cfg[5], rows[r].cfg[6], rows[r].cfg[7]}, 1'b0}); // Echo
      end
      // Levels from the core and echoed commands
      @(posedge hclk);
      main_power_on <= 1'b1;  overheat_warn <= 1'b1;
      brake_released <= 1'b1;  op_in <= 9'h155;
      repeat (3) @(posedge hclk);
      chk16({13'h0, main_power_status, overheat_out, brake_released_out},
            16'h0007); // Status on
      chk16({7'h0, op_echo}, 16'h0155); // Echo
      main_power_on <= 1'b0;  overheat_warn <= 1'b0;  op_in <= 9'h0aa;
      brake_released <= 1'b0;
      repeat (3) @(posedge hclk);
      chk16({13'h0, main_power_status, overheat_out, brake_released_out},
            16'h0000); // Status off
      chk16({7'h0, op_echo}, 16'h00aa); // Echo
      // General signals, with a slow far side
      lag <= 3'h5;
      ahb(1'b1, mdio_pkg::OFS_NETIN, 32'h0000a5a5, rd);
      ahb(1'b1, mdio_pkg::OFS_ROUTE, 32'h0000ff00, rd);
      ahb(1'b1, mdio_pkg::OFS_GPOL, 32'h0000000f, rd);
      repeat (12) @(posedge hclk);
      chk16(direct_out, 16'ha500); // Net to pin
      ahb(1'b1, mdio_pkg::OFS_ROUTE, 32'h0, rd);
      repeat (12) @(posedge hclk);
      chk16(direct_out, 16'h0000); // Route off
      ahb(1'b0, mdio_pkg::OFS_NETOUT, 32'h0, rd);
      chk32(rd, 32'h0000123b); // Pin to net
      // Read-only, clamped, reserved and unmapped places
      ahb(1'b1, mdio_pkg::OFS_NETOUT, 32'hffffffff, rd);
      ahb(1'b0, mdio_pkg::OFS_NETOUT, 32'h0, rd);
      chk32(rd, 32'h0000123b); // Write ignored
      ahb(1'b1, mdio_pkg::OFS_BAND, 32'h0, rd);
      ahb(1'b0, mdio_pkg::OFS_BAND, 32'h0, rd);
      chk32(rd, 32'h00000001); // Low clamp
      ahb(1'b1, mdio_pkg::OFS_BAND, 32'h0000ffff, rd);
      ahb(1'b0, mdio_pkg::OFS_BAND, 32'h0, rd);
      chk32(rd, 32'h00000e10); // High clamp
      ahb(1'b1, mdio_pkg::OFS_CONFIG, 32'h00000007, rd);
      ahb(1'b0, mdio_pkg::OFS_CONFIG, 32'h0, rd);
      chk32(rd, 32'h00000001); // Action 3 kept as none
      ahb(1'b0, 8'h30, 32'h0, rd);
      chk32(rd, 32'h0);
      chk16({15'h0, hresp}, 16'h0000);
      // Encoder index: short pulse still gives a held output
      lag <= 3'h0;
      index_go <= 1'b1;
      @(posedge hclk);
      index_go <= 1'b0;
      repeat (8) @(posedge hclk);
      chk16({15'h0, encoder_index_out}, 16'h0001); // Prompt
      repeat (1000) @(posedge hclk);
      chk16({15'h0, encoder_index_out}, 16'h0001); // Held
      // Reset in mid-run clears state and restores defaults
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk16({12'h0, hreadyout, encoder_index_out, stepout_out,
             main_power_status}, 16'h0008);
      hresetn <= 1'b1;
      ahb(1'b0, mdio_pkg::OFS_CONFIG, 32'h0, rd);
      chk32(rd, 32'h00000008); // Defaults
      ahb(1'b0, mdio_pkg::OFS_BAND, 32'h0, rd);
      chk32(rd, 32'h00000048); // Default band
      conclude();
   end
endmodule
`default_nettype wire
